/* core/stpt_port_fsm.sv */
// state machine and forward delay dwell timer of one port
`timescale 1ns/10ps
module stpt_port_fsm
  import stpt_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // link to the top
  stpt_port_if.fsm  pif
);
  stpt_state_t state_q;
  stpt_state_t state_d;
  logic [7:0]  dwell_q;
  logic [7:0]  dwell_d;
  logic        hold_ok;
  logic        dwell_done;
  logic        timed;

  // a port may progress only while the protocol runs and the role allows it
  assign hold_ok    = pif.admin_en & pif.stp_en & pif.role_fwd;
  assign dwell_done = (dwell_q >= pif.fwd_delay);
  assign timed      = (state_q == STPT_LISTENING) | (state_q == STPT_LEARNING);
  assign pif.state  = state_q;

  // legal moves only; a fallback from listening or learning goes via disabled
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      STPT_BLOCKING:
        if (!pif.admin_en) state_d = STPT_DISABLED;
        else if (pif.stp_en & pif.role_fwd) state_d = STPT_LISTENING;
      STPT_LISTENING:
        if (!hold_ok) state_d = STPT_DISABLED;
        else if (dwell_done) state_d = STPT_LEARNING;
      STPT_LEARNING:
        if (!hold_ok) state_d = STPT_DISABLED;
        else if (dwell_done) state_d = STPT_FORWARDING;
      STPT_FORWARDING:
        if (!hold_ok) state_d = STPT_DISABLED;
      STPT_DISABLED:
        if (pif.admin_en) state_d = STPT_BLOCKING;
    endcase
  end

  // dwell counts whole seconds since entering listening or learning
  assign dwell_d = (!timed || state_d != state_q) ? 8'h00 :
                   (pif.tick && dwell_q != 8'hff) ? dwell_q + 8'h01 : dwell_q;

  // every port starts out blocking after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= STPT_BLOCKING;
      dwell_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      dwell_q <= dwell_d;
    end
  end
endmodule

/* core/stpt_tick_gen.sv */
// one-second tick derived from the bus clock
`timescale 1ns/10ps
module stpt_tick_gen #(
  parameter int CYCLES = 20000000
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // tick out
  output logic      tick
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_q;

  // wrap at the last cycle so the tick repeats exactly once per period
  assign cnt_d = (cnt_q == LAST) ? '0 : cnt_q + W'(1);
  assign tick  = tick_q;

  // counter restarts from zero on reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= (cnt_q == LAST);
    end
  end
endmodule

/* core/stpt_top.sv */
// spanning tree port states, bridge timers and parameter registers over apb
// Operation
// - every port holds exactly one of five states
// - after reset each port starts in blocking
// - blocking goes to listening or disabled; listening to learning or disabled
// - learning goes only to forwarding or disabled
// - forwarding goes only to disabled; disabled only back to blocking
// - blocking port neither sends nor takes data frames; with the protocol off its data gates follow admin instead
// - learning port learns source addresses but forwards nothing
// - disabled port carries management traffic only
// - protocol ports pass only protocol frames until forwarding
// - listening and learning each last the forward delay
// - bridge id is 16-bit priority then 48-bit address, priority 32768
// - bridge priority 0 to 65535, lower ranks higher
// - hello 1 to 10 s, default 2; root sends once per hello
// - own hello applies only as root, value kept meanwhile
// - hello longer than maximum age flags a configuration error
// - maximum age 6 to 40 s, default 20; older frames dropped
// - maximum age expiry without root frames makes the bridge bid root
// - lowest bridge id among competitors becomes root
// - forward delay 4 to 30 s sets the listening dwell
// - maximum age within 2*(fwd-1) above and 2*(hello+1) below
// - port priority 0 to 240, default 128, lower preferred
// - port cost 0 to 200000000, 0 picks speed-based cost
// - reset leaves protocol off, port priority 128, cost 0, priority 32768
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "stpt_params.svh"
module stpt_top
  import stpt_pkg::*;
#(
  parameter int NPORTS      = 8,
  parameter int TICK_CYCLES = `STPT_CLK_HZ * `STPT_TICK_S
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // bridge identity and root status
  input  wire logic [47:0]       bridge_mac,
  output logic      [63:0]       bridge_id,
  output logic                   is_root,
  output logic                   hello_tx,
  output logic                   cfg_err,
  // received protocol frame summary
  input  wire logic              bpdu_rx_valid,
  input  wire logic [63:0]       bpdu_root_id,
  input  wire logic [7:0]        bpdu_age,
  output logic                   bpdu_drop,
  // per-port role and speed from the election logic
  input  wire logic [NPORTS-1:0] port_role_fwd,
  input  wire logic [NPORTS-1:0] port_gig,
  // per-port frame gates
  output logic      [NPORTS-1:0] tx_data_en,
  output logic      [NPORTS-1:0] rx_data_en,
  output logic      [NPORTS-1:0] learn_en,
  output logic      [NPORTS-1:0] bpdu_en,
  output logic      [NPORTS-1:0] mgmt_only
);
  localparam int PW = (NPORTS > 1) ? $clog2(NPORTS) : 1;

  // ***************************************************************
  // decoding helpers
  // ***************************************************************

  // range test shared by every checked register write
  function automatic logic fn_in_range(input logic [31:0] v, input logic [31:0] lo,
                                       input logic [31:0] hi);
    fn_in_range = (v >= lo) && (v <= hi);
  endfunction

  // ***************************************************************
  // storage
  // ***************************************************************

  logic              stp_en_q;
  logic [15:0]       bprio_q;
  logic [7:0]        hello_q;
  logic [7:0]        maxage_q;
  logic [7:0]        fwddly_q;
  logic [PW-1:0]     psel_q;
  logic [7:0]        pprio_q [NPORTS];
  logic [27:0]       pcost_q [NPORTS];
  logic [NPORTS-1:0] padmin_q;
  logic [31:0]       prdata_q;
  logic [47:0]       mac_q;
  logic [63:0]       root_best_q;
  logic [7:0]        age_cnt_q;
  logic [7:0]        hello_cnt_q;
  logic              was_root_q;
  logic              hello_tx_q;
  logic              bpdu_drop_q;
  logic              tick;
  stpt_state_t       pstate [NPORTS];

  // ***************************************************************
  // one-second tick
  // ***************************************************************

  stpt_tick_gen #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // ***************************************************************
  // apb decode
  // ***************************************************************

  logic        acc;
  logic        wr;
  logic        rd_setup;
  logic        hit;
  logic        ro_hit;
  logic        wr_bad;
  logic [31:0] wd;
  logic [7:0]  wd8;

  // registers answer in the access phase; read data is latched at setup
  assign acc      = psel & penable;
  assign wr       = acc & pwrite & ~wr_bad;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wd       = pwdata;
  assign wd8      = pwdata[7:0];
  assign hit      = (paddr[1:0] == 2'b00) && (paddr <= `STPT_OFS_ROOTHI);
  assign ro_hit   = (paddr == `STPT_OFS_STATUS) || (paddr == `STPT_OFS_PSTATE) ||
                    (paddr == `STPT_OFS_PEFF) || (paddr == `STPT_OFS_ROOTLO) ||
                    (paddr == `STPT_OFS_ROOTHI);

  // out-of-range values are refused whole and the old setting stays
  assign wr_bad = !hit || ro_hit ||
    ((paddr == `STPT_OFS_BPRIO) && !fn_in_range(wd, 32'h0, 32'h0000ffff)) ||
    ((paddr == `STPT_OFS_HELLO) &&
     !fn_in_range(wd, 32'(`STPT_HELLO_MIN), 32'(`STPT_HELLO_MAX))) ||
    ((paddr == `STPT_OFS_MAXAGE) &&
     !fn_in_range(wd, 32'(`STPT_MAXAGE_MIN), 32'(`STPT_MAXAGE_MAX))) ||
    ((paddr == `STPT_OFS_FWDDLY) &&
     !fn_in_range(wd, 32'(`STPT_FWDDLY_MIN), 32'(`STPT_FWDDLY_MAX))) ||
    ((paddr == `STPT_OFS_PSEL) && !fn_in_range(wd, 32'h0, 32'(NPORTS - 1))) ||
    ((paddr == `STPT_OFS_PPRIO) && !fn_in_range(wd, 32'h0, 32'(`STPT_PPRIO_MAX))) ||
    ((paddr == `STPT_OFS_PCOST) && !fn_in_range(wd, 32'h0, 32'(`STPT_PCOST_MAX)));

  assign pready  = 1'b1;
  assign pslverr = acc & (!hit | (pwrite & wr_bad));
  assign prdata  = prdata_q;

  // ***************************************************************
  // parameter consistency
  // ***************************************************************

  logic       hello_err;
  logic       fwd_err;
  logic       lo_err;
  logic [8:0] fwd_lim;
  logic [8:0] hello_lim;

  // the nine-bit limits cannot overflow for any accepted value
  assign fwd_lim   = {fwddly_q - `STPT_ONE_S, 1'b0};
  assign hello_lim = {hello_q + `STPT_ONE_S, 1'b0};
  assign hello_err = (hello_q > maxage_q);
  assign fwd_err   = ({1'b0, maxage_q} > fwd_lim);
  assign lo_err    = ({1'b0, maxage_q} < hello_lim);
  assign cfg_err   = hello_err | fwd_err | lo_err;

  // ***************************************************************
  // root election and bridge timers
  // ***************************************************************

  logic        rx_ok;
  logic        rx_better;
  logic        rx_refresh;
  logic        expire;
  logic        hello_due;
  logic [63:0] own_id;

  // the identifier compares as one 64-bit number, so lowest wins
  assign own_id     = {bprio_q, mac_q};
  assign bridge_id  = own_id;
  assign is_root    = (own_id < root_best_q);
  assign rx_ok      = bpdu_rx_valid & (bpdu_age <= maxage_q);
  assign rx_better  = rx_ok & (bpdu_root_id < root_best_q) & (bpdu_root_id < own_id);
  assign rx_refresh = rx_better | (rx_ok & (bpdu_root_id == root_best_q));
  assign expire     = ~is_root & ~rx_refresh & (age_cnt_q >= maxage_q);
  assign hello_due  = tick & (hello_cnt_q + `STPT_ONE_S >= hello_q);
  assign hello_tx   = hello_tx_q;
  assign bpdu_drop  = bpdu_drop_q;

  // forgetting the root lets the own identifier win and start sending
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      root_best_q <= `STPT_ROOT_NONE;
    else if (rx_better)
      root_best_q <= bpdu_root_id;
    else if (expire)
      root_best_q <= `STPT_ROOT_NONE;
  end

  // frame age counter and hello counter, both cleared by reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      age_cnt_q   <= 8'h00;
      hello_cnt_q <= 8'h00;
    end
    else
    begin
      age_cnt_q   <= (is_root | rx_refresh) ? 8'h00 :
                     (tick && age_cnt_q != 8'hff) ? age_cnt_q + 8'h01 : age_cnt_q;
      hello_cnt_q <= (!is_root || hello_due) ? 8'h00 :
                     tick ? hello_cnt_q + 8'h01 : hello_cnt_q;
    end
  end

  // a new root announces itself at once, then once per hello interval
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      was_root_q  <= 1'b0;
      hello_tx_q  <= 1'b0;
      bpdu_drop_q <= 1'b0;
      mac_q       <= 48'h0;
    end
    else
    begin
      was_root_q  <= is_root;
      hello_tx_q  <= is_root & (~was_root_q | hello_due);
      bpdu_drop_q <= bpdu_rx_valid & ~rx_ok;
      mac_q       <= bridge_mac;
    end
  end

  // ***************************************************************
  // bridge registers
  // ***************************************************************

  // bridge settings; a hello value is stored even while not root
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stp_en_q <= 1'b0;
      bprio_q  <= `STPT_DEF_BPRIO;
      hello_q  <= `STPT_DEF_HELLO;
      maxage_q <= `STPT_DEF_MAXAGE;
      fwddly_q <= `STPT_DEF_FWDDLY;
      psel_q   <= '0;
      padmin_q <= '1;
    end
    else if (wr)
    begin
      if (paddr == `STPT_OFS_CTRL)   stp_en_q <= wd[`STPT_CTRL_EN];
      if (paddr == `STPT_OFS_BPRIO)  bprio_q  <= wd[15:0];
      if (paddr == `STPT_OFS_HELLO)  hello_q  <= wd8;
      if (paddr == `STPT_OFS_MAXAGE) maxage_q <= wd8;
      if (paddr == `STPT_OFS_FWDDLY) fwddly_q <= wd8;
      if (paddr == `STPT_OFS_PSEL)   psel_q   <= wd[PW-1:0];
      if (paddr == `STPT_OFS_PADMIN) padmin_q <= wd[NPORTS-1:0];
    end
  end

  // ***************************************************************
  // per-port registers, reached through the port select
  // ***************************************************************

  logic [27:0] eff_cost;
  logic [27:0] sel_cost;

  // zero cost means the speed-based value is used
  assign sel_cost = pcost_q[psel_q];
  assign eff_cost = (sel_cost != `STPT_DEF_PCOST) ? sel_cost :
                    port_gig[psel_q] ? `STPT_COST_GE : `STPT_COST_FE;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NPORTS; i++)
      begin
        pprio_q[i] <= `STPT_DEF_PPRIO;
        pcost_q[i] <= `STPT_DEF_PCOST;
      end
    end
    else if (wr)
    begin
      if (paddr == `STPT_OFS_PPRIO) pprio_q[psel_q] <= wd8;
      if (paddr == `STPT_OFS_PCOST) pcost_q[psel_q] <= wd[27:0];
    end
  end

  // ***************************************************************
  // read path
  // ***************************************************************

  logic [31:0] rd_mux;
  logic [31:0] status_w;

  assign status_w = {29'h0, is_root, hello_err, cfg_err};

  // unmapped addresses read as zero
  assign rd_mux =
    (paddr == `STPT_OFS_CTRL)   ? {31'h0, stp_en_q} :
    (paddr == `STPT_OFS_BPRIO)  ? {16'h0, bprio_q} :
    (paddr == `STPT_OFS_HELLO)  ? {24'h0, hello_q} :
    (paddr == `STPT_OFS_MAXAGE) ? {24'h0, maxage_q} :
    (paddr == `STPT_OFS_FWDDLY) ? {24'h0, fwddly_q} :
    (paddr == `STPT_OFS_STATUS) ? status_w :
    (paddr == `STPT_OFS_PSEL)   ? 32'(psel_q) :
    (paddr == `STPT_OFS_PPRIO)  ? {24'h0, pprio_q[psel_q]} :
    (paddr == `STPT_OFS_PCOST)  ? {4'h0, sel_cost} :
    (paddr == `STPT_OFS_PADMIN) ? 32'(padmin_q) :
    (paddr == `STPT_OFS_PSTATE) ? {29'h0, pstate[psel_q]} :
    (paddr == `STPT_OFS_PEFF)   ? {4'h0, eff_cost} :
    (paddr == `STPT_OFS_ROOTLO) ? root_best_q[31:0] :
    (paddr == `STPT_OFS_ROOTHI) ? root_best_q[63:32] : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0;
    else if (rd_setup)
      prdata_q <= rd_mux;
  end

  // ***************************************************************
  // port state machines and frame gates
  // ***************************************************************

  stpt_port_if pif [NPORTS] ();

  // with the protocol off a port switches plainly, gated only by admin
  for (genvar n = 0; n < NPORTS; n++)
  begin : g_port
    logic fwd;
    logic lrn;
    logic dis;

    assign pif[n].tick      = tick;
    assign pif[n].fwd_delay = fwddly_q;
    assign pif[n].stp_en    = stp_en_q;
    assign pif[n].admin_en  = padmin_q[n];
    assign pif[n].role_fwd  = port_role_fwd[n];
    assign pstate[n]        = pif[n].state;

    stpt_port_fsm u_fsm (
      .pclk    (pclk),
      .presetn (presetn),
      .pif     (pif[n])
    );

    assign fwd = (pstate[n] == STPT_FORWARDING);
    assign lrn = (pstate[n] == STPT_LEARNING);
    assign dis = (pstate[n] == STPT_DISABLED);

    // blocking and listening ports carry protocol frames only
    assign tx_data_en[n] = stp_en_q ? fwd : padmin_q[n];
    assign rx_data_en[n] = stp_en_q ? fwd : padmin_q[n];
    assign learn_en[n]   = stp_en_q ? (fwd | lrn) : padmin_q[n];
    assign bpdu_en[n]    = stp_en_q & ~dis;
    assign mgmt_only[n]  = stp_en_q ? dis : ~padmin_q[n];
  end

endmodule

/* dv/stpt_peer_model.sv */
// peer bridge sending protocol frame summaries
`timescale 1ns/10ps
module stpt_peer_model (
  // clock
  input wire logic pclk,
  // frame summary
  output logic        vld,
  output logic [63:0] id,
  output logic [7:0]  age
);
  // idle lines at time zero
  initial
  begin
    vld = 1'b0;
    id = '0;
    age = '0;
  end
  // one frame for one cycle; fields scramble after release so stale data never matches
  task automatic send(input logic [63:0] i, input logic [7:0] a);
    @(posedge pclk);
    vld <= 1'b1;
    id <= i;
    age <= a;
    @(posedge pclk);
    vld <= 1'b0;
    id <= ~i;
    age <= ~a;
  endtask
endmodule

/* dv/stpt_top_chk.sv */
// concurrent checks on the top ports of the port state block
`timescale 1ns/10ps
module stpt_top_chk #(
  parameter int NPORTS = 8
) (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // identity and frames
  input wire logic [47:0]       bridge_mac,
  input wire logic [63:0]       bridge_id,
  input wire logic              is_root,
  input wire logic              hello_tx,
  input wire logic              bpdu_rx_valid,
  input wire logic [63:0]       bpdu_root_id,
  input wire logic [7:0]        bpdu_age,
  input wire logic              bpdu_drop,
  // port gates
  input wire logic [NPORTS-1:0] tx_data_en,
  input wire logic [NPORTS-1:0] rx_data_en,
  input wire logic [NPORTS-1:0] bpdu_en,
  input wire logic [NPORTS-1:0] mgmt_only
);
  // ****
  // one domain; the address flop is empty on the first edge out of reset
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_bid_mac: assert property ($past(presetn) |-> bridge_id[47:0] == $past(bridge_mac))
    else $error("bridge id address part wrong");
  chk_gate_pair: assert property (tx_data_en == rx_data_en)
    else $error("send and receive gates differ");
  chk_mgmt_gate: assert property ((mgmt_only & (tx_data_en | rx_data_en)) == '0)
    else $error("data gate open on management-only port");
  chk_hello_gap: assert property (hello_tx |=> !hello_tx [*8])
    else $error("hello pulses too close");
  chk_hello_root: assert property (hello_tx |-> $past(is_root))
    else $error("hello sent while not root");
  chk_drop_cause: assert property (bpdu_drop |-> $past(bpdu_rx_valid))
    else $error("drop without a frame");
  chk_drop_old: assert property (bpdu_rx_valid && bpdu_age > 8'h28 |=> bpdu_drop)
    else $error("overaged frame kept");
  chk_root_lose: assert property (bpdu_rx_valid && bpdu_age == 8'h00 &&
    bpdu_root_id < bridge_id |=> !is_root)
    else $error("lower root id not adopted");
  cover property (hello_tx);
  cover property (bpdu_drop);
  cover property ((tx_data_en & bpdu_en) != '0);
endmodule
bind stpt_top stpt_top_chk #(.NPORTS(NPORTS)) u_chk (.*);

/* dv/tb_spanning_tree_port_state_timers.sv */
// self-checking bench of the port state and timer block
`timescale 1ns/10ps
module tb_spanning_tree_port_state_timers;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        is_root, hello_tx, cfg_err, vld, bpdu_drop;
  logic [7:0]  paddr, age, role, gig, tx, rx, lrn, bpe, mgo, a;
  logic [31:0] pwdata, prdata, rd, d;
  logic [47:0] mac;
  logic [63:0] bid, rid;
  int          miscompares = 0, samples_checked = 0, seed = 2, cyc = 0, t0, prev;
  int unsigned mir[int];
  int          sq[$];
  int          ex[4] = '{0, 1, 2, 3};
  logic [39:0] rt[10] = '{{8'h00, 32'h0}, {8'h04, 32'h8000}, {8'h08, 32'h2},
    {8'h0c, 32'h14}, {8'h10, 32'hf}, {8'h1c, 32'h80}, {8'h20, 32'h0},
    {8'h24, 32'hff}, {8'h28, 32'h0}, {8'h30, 32'hffffffff}};
  logic [39:0] wt[19] = '{{8'h08, 32'd11}, {8'h08, 32'd0}, {8'h08, 32'd10},
    {8'h0c, 32'd5}, {8'h0c, 32'd41}, {8'h0c, 32'd40}, {8'h10, 32'd31}, {8'h10, 32'd3},
    {8'h10, 32'd4}, {8'h04, 32'h10000}, {8'h04, 32'h0}, {8'h04, 32'hffff},
    {8'h1c, 32'd241}, {8'h1c, 32'd240}, {8'h20, 32'd200000001}, {8'h20, 32'd5},
    {8'h30, 32'h1}, {8'h0c, 32'd6}, {8'h08, 32'd2}};
  // clock and cycle count
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  stpt_top #(.NPORTS(8), .TICK_CYCLES(10)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bridge_mac(mac),
    .bridge_id(bid), .is_root(is_root), .hello_tx(hello_tx), .cfg_err(cfg_err),
    .bpdu_rx_valid(vld), .bpdu_root_id(rid), .bpdu_age(age), .bpdu_drop(bpdu_drop),
    .port_role_fwd(role), .port_gig(gig), .tx_data_en(tx), .rx_data_en(rx),
    .learn_en(lrn), .bpdu_en(bpe), .mgmt_only(mgo));
  stpt_peer_model peer (.pclk(pclk), .vld(vld), .id(rid), .age(age));
  // ****
  // shared tasks and reference model
  // ****
  task automatic cmp(input string n, input logic [63:0] x, input logic [63:0] g);
    samples_checked++;
    if (g !== x)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endtask
  // one apb transfer; held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic bit legal(input logic [7:0] ad, input logic [31:0] v);
    case (ad)
      8'h04: return v < 32'h10000;
      8'h08: return v >= 1 && v <= 10;
      8'h0c: return v >= 6 && v <= 40;
      8'h10: return v >= 4 && v <= 30;
      8'h1c: return v <= 240;
      8'h20: return v <= 200000000;
      8'h30: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction
  function automatic bit cfg();
    return mir[8] > mir[12] || mir[12] > 2 * (mir[16] - 1) || mir[12] < 2 * (mir[8] + 1);
  endfunction
  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: the whole run needs well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    mac = 48'({$random(seed), $random(seed)});
    gig = 8'($random(seed));
    role = 8'hff;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rt[i])
    begin
      apb(0, rt[i][39:32], 0);
      mir[rt[i][39:32]] = rt[i][31:0];
      cmp("reset value", rt[i][31:0], rd);
    end
    apb(0, 8'h38, 0);
    cmp("unmapped error", 1, e);
    foreach (wt[i])
    begin
      {a, d} = wt[i];
      apb(1, a, d);
      cmp("write refused", !legal(a, d), e);
      if (legal(a, d)) mir[a] = d;
      apb(0, a, 0);
      cmp("readback", mir[a], rd);
      cmp("config error", cfg(), cfg_err);
    end
    cmp("bridge id", {16'hffff, mac}, bid);
    apb(0, 8'h2c, 0);
    cmp("set cost", 5, rd);
    apb(1, 8'h20, 0);
    apb(0, 8'h2c, 0);
    cmp("auto cost", gig[0] ? 20000 : 200000, rd);
    apb(1, 8'h00, 1);
    t0 = cyc;
    prev = 0;
    sq = '{0};
    repeat (60)
    begin
      apb(0, 8'h28, 0);
      if (rd != prev) sq.push_back(rd);
      if (rd != prev && rd == 2) cmp("learn gate", 2'b10, {lrn[0], tx[0]});
      prev = rd;
      if (rd == 3) break;
    end
    cmp("dwell", 1, cyc - t0 >= 60 && cyc - t0 <= 95);
    cmp("state count", 4, sq.size());
    foreach (ex[i]) cmp("state order", ex[i], sq[i]);
    cmp("forward gate", 3'b111, {tx[0], bpe[0], lrn[0]});
    role <= 8'hfe;
    repeat (3) @(posedge pclk);
    apb(0, 8'h28, 0);
    cmp("back to blocking", 0, rd);
    cmp("block gate", 3'b001, {tx[0], rx[0], bpe[0]});
    apb(1, 8'h24, 8'hfe);
    repeat (2) @(posedge pclk);
    apb(0, 8'h28, 0);
    cmp("disabled", 4, rd);
    cmp("mgmt gate", 5'b10000, {mgo[0], tx[0], rx[0], lrn[0], bpe[0]});
    peer.send(64'h1, 8'h00);
    t0 = cyc;
    repeat (2) @(posedge pclk);
    cmp("root lost", 0, is_root);
    peer.send(64'h0, 8'h30);
    apb(0, 8'h30, 0);
    cmp("old frame ignored", 1, rd);
    while (is_root !== 1'b1 && cyc - t0 < 200) @(posedge pclk);
    cmp("age expiry", 1, cyc - t0 >= 45 && cyc - t0 <= 80);
    t0 = cyc;
    while (hello_tx !== 1'b1 && cyc - t0 < 5) @(posedge pclk);
    cmp("hello on root", 1, hello_tx);
    t0 = cyc;
    do @(posedge pclk); while (hello_tx !== 1'b1 && cyc - t0 < 40);
    cmp("hello period", 1, cyc - t0 > 10 && cyc - t0 <= 20);
    // mid-run reset: every register and the port state fall back to defaults
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rt[i])
    begin
      apb(0, rt[i][39:32], 0);
      cmp("value after reset", rt[i][31:0], rd);
    end
    stop_test();
  end
endmodule

/* shared/stpt_params.svh */
// constants of the spanning tree port state and timer block
`ifndef STPT_PARAMS_SVH
`define STPT_PARAMS_SVH

// register byte offsets
`define STPT_OFS_CTRL    8'h00
`define STPT_OFS_BPRIO   8'h04
`define STPT_OFS_HELLO   8'h08
`define STPT_OFS_MAXAGE  8'h0c
`define STPT_OFS_FWDDLY  8'h10
`define STPT_OFS_STATUS  8'h14
`define STPT_OFS_PSEL    8'h18
`define STPT_OFS_PPRIO   8'h1c
`define STPT_OFS_PCOST   8'h20
`define STPT_OFS_PADMIN  8'h24
`define STPT_OFS_PSTATE  8'h28
`define STPT_OFS_PEFF    8'h2c
`define STPT_OFS_ROOTLO  8'h30
`define STPT_OFS_ROOTHI  8'h34

// field positions
`define STPT_CTRL_EN     0
`define STPT_ST_CFGERR   0
`define STPT_ST_HELLOERR 1
`define STPT_ST_ROOT     2

// reset values
`define STPT_DEF_BPRIO   16'h8000
`define STPT_DEF_HELLO   8'h02
`define STPT_DEF_MAXAGE  8'h14
`define STPT_DEF_FWDDLY  8'h0f
`define STPT_DEF_PPRIO   8'h80
`define STPT_DEF_PCOST   28'h0000000
`define STPT_ROOT_NONE   64'hffff_ffff_ffff_ffff

// accepted ranges, seconds or raw units
`define STPT_HELLO_MIN   8'h01
`define STPT_HELLO_MAX   8'h0a
`define STPT_MAXAGE_MIN  8'h06
`define STPT_MAXAGE_MAX  8'h28
`define STPT_FWDDLY_MIN  8'h04
`define STPT_FWDDLY_MAX  8'h1e
`define STPT_PPRIO_MAX   8'hf0
`define STPT_PCOST_MAX   28'hbebc200
`define STPT_COST_FE     28'h0030d40
`define STPT_COST_GE     28'h0004e20
`define STPT_ONE_S       8'h01

// timing
`define STPT_CLK_HZ      20000000
`define STPT_TICK_S      1

`endif

/* shared/stpt_pkg.sv */
// types of the spanning tree port state and timer block
package stpt_pkg;

  // spanning tree state of one port
  typedef enum logic [2:0] {
    STPT_BLOCKING,
    STPT_LISTENING,
    STPT_LEARNING,
    STPT_FORWARDING,
    STPT_DISABLED
  } stpt_state_t;

endpackage

/* shared/stpt_port_if.sv */
// control and state signals between the top and one port state machine
`timescale 1ns/10ps
interface stpt_port_if;
  import stpt_pkg::*;

  logic        tick;
  logic [7:0]  fwd_delay;
  logic        stp_en;
  logic        admin_en;
  logic        role_fwd;
  stpt_state_t state;

  modport ctl (output tick, output fwd_delay, output stp_en, output admin_en,
               output role_fwd, input state);
  modport fsm (input tick, input fwd_delay, input stp_en, input admin_en,
               input role_fwd, output state);
endinterface
